// [hdl/kinetics_cfg.svh]
// Constants for the kinetics frame sequencer.
`ifndef KINETICS_CFG_SVH
`define KINETICS_CFG_SVH
`define KIN_MODE_FREE_RUN 2'h0
`define KIN_MODE_SINGLE_TRIG 2'h1
`define KIN_MODE_MULTI_TRIG 2'h2
`define KIN_MON_SEL_SHUTTER 1'h0
`define KIN_MON_SEL_READOUT 1'h1
`define KIN_CLK_PERIOD_NS 25
`define KIN_CLK_MHZ 40
`define KIN_DEF_ROWS 16'h0200
`define KIN_CNT_ONE 16'h0001
`define KIN_CNT_ZERO 16'h0000
`endif

// [hdl/kinetics_pkg.sv]
// Types shared by the kinetics frame sequencer files.
package kinetics_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_WAIT_START = 3'h1,
        ST_EXPOSE = 3'h2,
        ST_SHIFT = 3'h3,
        ST_WAIT_SYNC = 3'h4,
        ST_READOUT = 3'h5
    } seq_state_type;
endpackage

// [hdl/tick_divider.sv]
// Divider that produces a one-cycle enable pulse every period cycles.
`timescale 1ns/1ps
`include "kinetics_cfg.svh"
module tick_divider #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic run_i,
    input wire logic [WIDTH-1:0] period_i,
    output logic tick_o
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic tick_nxt;

    always_comb
    begin
        count_nxt = count_r;
        tick_nxt = 1'b0;
        if (!run_i)
        begin
            count_nxt = '0;
        end
        else if (count_r + WIDTH'(1) >= period_i)
        begin
            count_nxt = '0;
            tick_nxt = 1'b1;
        end
        else
        begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_r <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule // tick_divider

// [hdl/kinetics_frame_sequencer.sv]
// Kinetics acquisition sequencer: burst capture under a mask, then slow readout.
`timescale 1ns/1ps
`include "kinetics_cfg.svh"
module kinetics_frame_sequencer #(
    parameter int CNT_W = 16,
    parameter int SENSOR_ROWS = 512
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [1:0] mode_i,
    input wire logic [CNT_W-1:0] exposure_cycles_i,
    input wire logic [CNT_W-1:0] shift_cycles_i,
    input wire logic [CNT_W-1:0] window_rows_i,
    input wire logic [CNT_W-1:0] readout_cycles_i,
    input wire logic monitor_sel_i,
    input wire logic ext_sync_i,
    output logic shutter_open_o,
    output logic row_shift_o,
    output logic readout_o,
    output logic frame_done_o,
    output logic busy_o,
    output logic config_err_o,
    output logic timing_monitor_o
);
    if (CNT_W < 4 || SENSOR_ROWS < 1 || SENSOR_ROWS >= (1 << CNT_W))
    begin : g_param_check
        $error("kinetics_frame_sequencer: unsupported parameters");
    end

    localparam logic [CNT_W-1:0] ROWS = CNT_W'(SENSOR_ROWS);

    logic sync_meta_r;
    logic sync_s_r;
    logic sync_d_r;
    logic sync_rise;
    logic [2:0] sync_nxt;

    assign sync_nxt = {sync_meta_r, sync_s_r, ext_sync_i};
    assign sync_rise = sync_s_r && !sync_d_r;

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync_meta_r <= 1'b0;
            sync_s_r <= 1'b0;
            sync_d_r <= 1'b0;
        end
        else
        begin
            sync_meta_r <= sync_nxt[0];
            sync_s_r <= sync_nxt[2];
            sync_d_r <= sync_nxt[1];
        end
    end

    kinetics_pkg::seq_state_type state_r;
    kinetics_pkg::seq_state_type state_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [CNT_W-1:0] exp_r;
    logic [CNT_W-1:0] exp_nxt;
    logic [CNT_W-1:0] shift_r;
    logic [CNT_W-1:0] shift_nxt;
    logic [CNT_W-1:0] win_r;
    logic [CNT_W-1:0] win_nxt;
    logic [CNT_W-1:0] rdo_r;
    logic [CNT_W-1:0] rdo_nxt;
    logic [CNT_W-1:0] frames_r;
    logic [CNT_W-1:0] frames_nxt;
    logic [CNT_W-1:0] frame_idx_r;
    logic [CNT_W-1:0] frame_idx_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] rows_left_r;
    logic [CNT_W-1:0] rows_left_nxt;
    logic shutter_nxt;
    logic row_shift_nxt;
    logic readout_nxt;
    logic frame_done_nxt;
    logic busy_nxt;
    logic err_nxt;
    logic err_r;
    logic mon_nxt;
    logic shift_run;
    logic shift_tick;
    logic cfg_ok;
    logic last_frame;

    assign cfg_ok = (window_rows_i != `KIN_CNT_ZERO) && (window_rows_i <= ROWS)
        && (mode_i != 2'h3);
    assign last_frame = (frame_idx_r + `KIN_CNT_ONE) >= frames_r;
    assign shift_run = (state_r == kinetics_pkg::ST_SHIFT);

    tick_divider #(
        .WIDTH(CNT_W)
    ) u_row_tick (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .run_i(shift_run),
        .period_i(shift_r),
        .tick_o(shift_tick)
    );

    always_comb
    begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        exp_nxt = exp_r;
        shift_nxt = shift_r;
        win_nxt = win_r;
        rdo_nxt = rdo_r;
        frames_nxt = frames_r;
        frame_idx_nxt = frame_idx_r;
        cnt_nxt = cnt_r;
        rows_left_nxt = rows_left_r;
        frame_done_nxt = 1'b0;
        row_shift_nxt = 1'b0;
        err_nxt = err_r;
        unique case (state_r)
            kinetics_pkg::ST_IDLE:
            begin
                if (start_i)
                begin
                    if (!cfg_ok)
                    begin
                        err_nxt = 1'b1;
                    end
                    else
                    begin
                        err_nxt = 1'b0;
                        mode_nxt = mode_i;
                        exp_nxt = exposure_cycles_i;
                        shift_nxt = shift_cycles_i;
                        win_nxt = window_rows_i;
                        rdo_nxt = readout_cycles_i;
                        frames_nxt = ROWS / window_rows_i;
                        frame_idx_nxt = `KIN_CNT_ZERO;
                        cnt_nxt = `KIN_CNT_ZERO;
                        if (mode_i == `KIN_MODE_FREE_RUN)
                        begin
                            state_nxt = kinetics_pkg::ST_EXPOSE;
                        end
                        else
                        begin
                            state_nxt = kinetics_pkg::ST_WAIT_START;
                        end
                    end
                end
            end
            kinetics_pkg::ST_WAIT_START:
            begin
                if (sync_rise)
                begin
                    cnt_nxt = `KIN_CNT_ZERO;
                    state_nxt = (mode_r == `KIN_MODE_SINGLE_TRIG) ? kinetics_pkg::ST_EXPOSE
                        : kinetics_pkg::ST_WAIT_SYNC;
                end
            end
            kinetics_pkg::ST_EXPOSE:
            begin
                cnt_nxt = cnt_r + `KIN_CNT_ONE;
                if (cnt_nxt >= exp_r)
                begin
                    cnt_nxt = `KIN_CNT_ZERO;
                    rows_left_nxt = win_r;
                    state_nxt = kinetics_pkg::ST_SHIFT;
                end
            end
            kinetics_pkg::ST_WAIT_SYNC:
            begin
                if (sync_rise)
                begin
                    rows_left_nxt = win_r;
                    state_nxt = kinetics_pkg::ST_SHIFT;
                end
            end
            kinetics_pkg::ST_SHIFT:
            begin
                if (shift_tick)
                begin
                    row_shift_nxt = 1'b1;
                    rows_left_nxt = rows_left_r - `KIN_CNT_ONE;
                    if (rows_left_r == `KIN_CNT_ONE)
                    begin
                        frame_done_nxt = 1'b1;
                        frame_idx_nxt = frame_idx_r + `KIN_CNT_ONE;
                        cnt_nxt = `KIN_CNT_ZERO;
                        if (last_frame)
                        begin
                            state_nxt = kinetics_pkg::ST_READOUT;
                        end
                        else if (mode_r == `KIN_MODE_MULTI_TRIG)
                        begin
                            state_nxt = kinetics_pkg::ST_WAIT_SYNC;
                        end
                        else
                        begin
                            state_nxt = kinetics_pkg::ST_EXPOSE;
                        end
                    end
                end
            end
            kinetics_pkg::ST_READOUT:
            begin
                cnt_nxt = cnt_r + `KIN_CNT_ONE;
                if (cnt_nxt >= rdo_r)
                begin
                    cnt_nxt = `KIN_CNT_ZERO;
                    state_nxt = kinetics_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = kinetics_pkg::ST_IDLE;
            end
        endcase
        shutter_nxt = (state_nxt == kinetics_pkg::ST_EXPOSE) || (state_nxt == kinetics_pkg::ST_SHIFT)
            || (state_nxt == kinetics_pkg::ST_WAIT_SYNC);
        readout_nxt = (state_nxt == kinetics_pkg::ST_READOUT);
        busy_nxt = (state_nxt != kinetics_pkg::ST_IDLE);
        mon_nxt = (monitor_sel_i == `KIN_MON_SEL_READOUT) ? !readout_nxt : shutter_nxt;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= kinetics_pkg::ST_IDLE;
            mode_r <= `KIN_MODE_FREE_RUN;
            exp_r <= '0;
            shift_r <= '0;
            win_r <= '0;
            rdo_r <= '0;
            frames_r <= '0;
            frame_idx_r <= '0;
            cnt_r <= '0;
            rows_left_r <= '0;
            err_r <= 1'b0;
            shutter_open_o <= 1'b0;
            row_shift_o <= 1'b0;
            readout_o <= 1'b0;
            frame_done_o <= 1'b0;
            busy_o <= 1'b0;
            timing_monitor_o <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            exp_r <= exp_nxt;
            shift_r <= shift_nxt;
            win_r <= win_nxt;
            rdo_r <= rdo_nxt;
            frames_r <= frames_nxt;
            frame_idx_r <= frame_idx_nxt;
            cnt_r <= cnt_nxt;
            rows_left_r <= rows_left_nxt;
            err_r <= err_nxt;
            shutter_open_o <= shutter_nxt;
            row_shift_o <= row_shift_nxt;
            readout_o <= readout_nxt;
            frame_done_o <= frame_done_nxt;
            busy_o <= busy_nxt;
            timing_monitor_o <= mon_nxt;
        end
    end

    assign config_err_o = err_r;

    a_shutter_closed_readout: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        readout_o |-> !shutter_open_o) else $error("Shutter open during readout.");
    a_mode_held_series: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (busy_o && $past(busy_o)) |-> $stable(mode_r)) else $error("Mode changed within a series.");
    a_no_rearm_readout: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r == kinetics_pkg::ST_READOUT) |=> (state_r inside {kinetics_pkg::ST_READOUT,
        kinetics_pkg::ST_IDLE})) else $error("Series restarted before readout end.");
    a_multi_shutter_open: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r == kinetics_pkg::ST_WAIT_SYNC) |-> shutter_open_o) else $error("Shutter shut between syncs.");
    a_multi_one_frame: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (mode_r == `KIN_MODE_MULTI_TRIG && state_r == kinetics_pkg::ST_WAIT_SYNC && !sync_rise)
        |=> state_r == kinetics_pkg::ST_WAIT_SYNC) else $error("Frame started without sync.");
    a_frame_count_limit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        busy_o |-> frame_idx_r <= frames_r) else $error("Too many frames.");
    a_shift_after_expose: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r == kinetics_pkg::ST_EXPOSE && state_nxt != kinetics_pkg::ST_EXPOSE)
        |=> state_r == kinetics_pkg::ST_SHIFT) else $error("Exposure not followed by shift.");
    a_monitor_select: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $stable(monitor_sel_i) && monitor_sel_i |=> timing_monitor_o == !readout_o)
        else $error("Monitor does not follow readout.");
    a_single_trig_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r == kinetics_pkg::ST_WAIT_START && mode_r == `KIN_MODE_SINGLE_TRIG && sync_rise)
        |=> state_r == kinetics_pkg::ST_EXPOSE) else $error("Trigger did not start series.");

    c_free_run: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_r == `KIN_MODE_FREE_RUN && frame_done_o);
    c_single_read: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_r == `KIN_MODE_SINGLE_TRIG && readout_o);
    c_multi_read: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        mode_r == `KIN_MODE_MULTI_TRIG && readout_o);
endmodule // kinetics_frame_sequencer

// [bench/sync_source.sv]
// Model of the external trigger source: evenly spaced sync pulses on request.
`timescale 1ns/1ps
module sync_source
(
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [7:0] pulses_i,
    input wire logic [15:0] gap_i,
    output logic ext_sync_o
);
    initial
    begin
        ext_sync_o = 1'b0;
        forever
        begin
            @(posedge go_i);
            for (int k = 0; k < int'(pulses_i); k++)
            begin
                repeat (gap_i) @(posedge sys_clk_i);
                ext_sync_o <= 1'b1;
                repeat (4) @(posedge sys_clk_i);
                ext_sync_o <= 1'b0;
            end
        end
    end
endmodule // sync_source

// [bench/testbench.sv]
// Self-checking testbench of the kinetics frame sequencer.
`timescale 1ns/1ps
module testbench;
    localparam int ROWS = 6;
    logic sys_clk_i, reset_n_i, start, sel, ext_sync, go;
    logic [1:0] mode;
    logic [15:0] expo, shift, win, ro, gap;
    logic [7:0] npulse;
    logic shutter, row_shift, readout, frame_done, busy, cerr, tm;
    int failures, n_checks, seed;
    int frames, rows, ro_cnt, falls, gap_err, ovl, mon_cnt, exp_err, mon_err;
    int divs[4] = '{1, 2, 3, 6};

    kinetics_frame_sequencer #(.SENSOR_ROWS(ROWS)) i_dut
    (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(start), .mode_i(mode),
        .exposure_cycles_i(expo), .shift_cycles_i(shift), .window_rows_i(win),
        .readout_cycles_i(ro), .monitor_sel_i(sel), .ext_sync_i(ext_sync),
        .shutter_open_o(shutter), .row_shift_o(row_shift), .readout_o(readout),
        .frame_done_o(frame_done), .busy_o(busy), .config_err_o(cerr), .timing_monitor_o(tm)
    );
    sync_source i_sync
    (
        .sys_clk_i(sys_clk_i), .go_i(go), .pulses_i(npulse), .gap_i(gap), .ext_sync_o(ext_sync)
    );

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic int at_least_one(input logic [15:0] v);
        return (v == 16'h0000) ? 1 : int'(v);
    endfunction

    task kick;
        @(posedge sys_clk_i) start <= 1'b1;
        @(posedge sys_clk_i) start <= 1'b0;
    endtask

    task run_series(input int w, input int s, input int e, input logic trig_each);
        int t, idle, last;
        logic sh_d;
        frames = 0; rows = 0; ro_cnt = 0; falls = 0; gap_err = 0; ovl = 0; mon_cnt = 0;
        exp_err = 0; mon_err = 0;
        t = 0; idle = 0; last = 0; sh_d = 1'b0;
        while (idle < 4 && t < 20000)
        begin
            @(negedge sys_clk_i);
            t++;
            if (frame_done === 1'b1) frames++;
            if (row_shift === 1'b1)
            begin
                if (rows % w != 0 && t - last != s) gap_err++;
                if (rows % w == 0 && rows > 0 && !trig_each && t - last != e + s + 1) exp_err++;
                rows++;
                last = t;
            end
            if (readout === 1'b1) ro_cnt++;
            if (readout === 1'b1 && shutter === 1'b1) ovl++;
            if (sh_d === 1'b1 && shutter === 1'b0) falls++;
            sh_d = shutter;
            if ((sel ? ~tm : tm) === 1'b1) mon_cnt++;
            if (tm !== (sel ? ~readout : shutter)) mon_err++;
            if (busy === 1'b0) idle++;
        end
        check("series ends", 1, t < 20000);
    endtask

    task series(input logic [1:0] m, input logic [15:0] e, input logic [15:0] s, input logic [15:0] w,
        input logic [15:0] r, input logic ms);
        int we, se;
        we = int'(w);
        se = at_least_one(s);
        @(posedge sys_clk_i);
        mode <= m; expo <= e; shift <= s; win <= w; ro <= r; sel <= ms;
        npulse <= (m == 2'h2) ? 8'(ROWS / we + 1) : 8'h01;
        gap <= 16'(2 * we * se + 20);
        kick();
        go <= (m != 2'h0);
        mode <= 2'($unsigned($random(seed)) % 3);
        win <= 16'(divs[$unsigned($random(seed)) % 4]);
        kick();
        go <= 1'b0;
        check("busy", 1, busy);
        if (m != 2'h0)
        begin
            repeat (8) @(negedge sys_clk_i);
            check("shutter before sync", 0, shutter);
        end
        run_series(we, se, at_least_one(e), m == 2'h2);
        check("frames", ROWS / we, frames);
        check("exposure length", 0, exp_err);
        check("monitor follows", 0, mon_err);
        check("rows", ROWS, rows);
        check("row spacing", 0, gap_err);
        check("readout length", at_least_one(r), ro_cnt);
        check("shutter closes once", 1, falls);
        check("readout overlap", 0, ovl);
        check("busy after", 0, busy);
        check("config error", 0, cerr);
        if (ms)
            check("monitor readout", at_least_one(r), mon_cnt);
    endtask

    task bad(input logic [1:0] m, input logic [15:0] w);
        @(posedge sys_clk_i);
        mode <= m;
        win <= w;
        kick();
        repeat (4) @(negedge sys_clk_i);
        check("bad config flag", 1, cerr);
        check("bad config idle", 0, busy);
    endtask

    initial
    begin
        #1000000;
        failures++;
        $display("[FAIL] watchdog expected end seen timeout");
        stop_test();
    end

    initial
    begin
        failures = 0; n_checks = 0; seed = 15483;
        reset_n_i = 1'b0; start = 1'b0; mode = 2'h0; sel = 1'b0; go = 1'b0;
        expo = 16'h0004; shift = 16'h0002; win = 16'h0002; ro = 16'h0008;
        gap = 16'h0014; npulse = 8'h01;
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check("monitor idle", 0, tm);
        bad(2'h3, 16'h0002);
        bad(2'h0, 16'h0000);
        bad(2'h0, 16'h0007);
        series(2'h0, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 1'b1);
        series(2'h0, 16'h0000, 16'h0000, 16'h0006, 16'h0000, 1'b1);
        series(2'h1, 16'h0003, 16'h0002, 16'h0002, 16'h000a, 1'b0);
        series(2'h2, 16'h0003, 16'h0003, 16'h0002, 16'h0005, 1'b1);
        series(2'h2, 16'h0002, 16'h0001, 16'h0001, 16'h0003, 1'b1);
        repeat (8)
        begin
            series(2'($unsigned($random(seed)) % 3), 16'($unsigned($random(seed)) % 9),
                16'($unsigned($random(seed)) % 5), 16'(divs[$unsigned($random(seed)) % 4]),
                16'($unsigned($random(seed)) % 17), 1'($random(seed)));
        end
        stop_test();
    end
endmodule // testbench
